// file: hdl/itd_dispatch.sv
// Our own choices: the address map and register access over AHB-Lite.
`include "itd_regs.svh"

module itd_dispatch
  import itd_pkg::*;
#(
  parameter int NTERM = 8
) (
  input wire logic hclk, // System clock, 20 MHz.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size, word only.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic [31:0] hrdata, // Read data.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Always OKAY.
  input wire logic [NTERM-1:0] term_in, // Terminal levels, high is valid.
  input wire logic stop_req, // Stop command from the core.
  output logic ramp_hold, // Freeze output frequency.
  output logic cnt_enable, // Pulse counter enable.
  output logic cnt_clear, // Pulse counter clear pulse.
  output logic trim_bypass, // Ignore up/down trim.
  output logic dc_brake_start, // DC brake start pulse.
  output logic motor2_sel, // Second motor parameter set.
  output itd_src_t run_src, // Effective run-command source.
  output logic preexcite, // Motor pre-excitation.
  output logic energy_clear, // Energy counter clear pulse.
  output logic energy_hold, // Energy counter hold.
  output logic trq_lim_keypad, // Upper torque limit from keypad.
  output logic pos_ref, // Position reference point.
  output logic orient_disable, // Spindle orientation disabled.
  output logic spindle_pos_trig // Spindle positioning pulse.
);

  localparam int CW = `ITD_CODE_W;
  localparam int IW = (NTERM > 1) ? $clog2(NTERM) : 1;

  // ****************************************
  // Decoding helper
  // ****************************************
  // True when any of the first lim terminals is valid and holds the code.
  function automatic logic fn_any(input logic [NTERM*CW-1:0] sel,
                                  input logic [NTERM-1:0] lvl,
                                  input logic [CW-1:0] code,
                                  input int lim);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NTERM; i++) begin
      if (i < lim && lvl[i] && sel[i*CW +: CW] == code) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // ****************************************
  // Bus slave
  // ****************************************
  logic wr_pend_r;
  logic [5:0] wr_idx_r;
  logic [31:0] hrdata_r;
  logic [1:0] cfg_src_r;
  logic [CW-1:0] sel_r [NTERM];
  logic [NTERM*CW-1:0] sel_flat;
  logic [NTERM-1:0] term_r;
  logic [15:0] status_w;

  wire accept = hsel & htrans[`ITD_HTRANS_NONSEQ_BIT] & hready;
  wire [5:0] a_idx = haddr[7:2];
  wire [5:0] cfg_idx = 6'(`ITD_OFF_CFG >> 2);
  wire [5:0] stat_idx = 6'(`ITD_OFF_STATUS >> 2);
  wire [5:0] term_idx = 6'(`ITD_OFF_TERM >> 2);
  wire a_sel_hit = a_idx < 6'(NTERM);
  wire [IW-1:0] a_sel_i = a_idx[IW-1:0];
  wire [31:0] rd_word =
    a_sel_hit ? 32'(sel_r[a_sel_i]) :
    (a_idx == cfg_idx) ? 32'(cfg_src_r) :
    (a_idx == stat_idx) ? 32'(status_w) :
    (a_idx == term_idx) ? 32'(term_r) : 32'h0000_0000;
  wire wr_cfg = wr_pend_r && wr_idx_r == cfg_idx;

  // Zero wait states: read data is registered at the address phase, so
  // a read issued in the data phase of a write to the same register
  // would see the old value; single transfers never overlap that way.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
    end else begin
      wr_pend_r <= accept & hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_idx_r <= 6'h00;
    end else if (accept) begin
      wr_idx_r <= a_idx;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (accept) begin
      hrdata_r <= hwrite ? 32'h0000_0000 : rd_word;
    end
  end

  assign hrdata = hrdata_r;

  // No wait states and no error answer: both flops only ever hold their
  // idle values, which keeps the answer free of any path from the decoder.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // A source code of 3 names nothing, so such a write leaves the setting alone.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_src_r <= `ITD_RST_CFG;
    end else if (wr_cfg && hwdata[1:0] <= 2'(ITD_SRC_COMM)) begin
      cfg_src_r <= hwdata[1:0];
    end
  end

  // Each terminal's set value sits in its own flop word, scanned by index.
  for (genvar g = 0; g < NTERM; g++) begin : g_sel
    wire wr_sel = wr_pend_r && wr_idx_r == 6'(g);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sel_r[g] <= `ITD_RST_SEL;
      end else if (wr_sel) begin
        sel_r[g] <= hwdata[CW-1:0];
      end
    end
    assign sel_flat[g*CW +: CW] = sel_r[g];
  end

  // ****************************************
  // Function dispatch
  // ****************************************
  // Only listed codes are decoded, so any other set value is inert.
  wire f_hold = fn_any(sel_flat, term_r, `ITD_FN_RAMP_HOLD, NTERM);
  wire f_cnt_en = fn_any(sel_flat, term_r, `ITD_FN_CNT_ENABLE, NTERM);
  wire f_cnt_clr = fn_any(sel_flat, term_r, `ITD_FN_CNT_RESET, NTERM);
  wire f_trim = fn_any(sel_flat, term_r, `ITD_FN_TRIM_CLEAR, NTERM);
  wire f_dcb = fn_any(sel_flat, term_r, `ITD_FN_DC_BRAKE, NTERM);
  wire f_m2 = fn_any(sel_flat, term_r, `ITD_FN_MOTOR2, NTERM);
  wire f_kp = fn_any(sel_flat, term_r, `ITD_FN_SRC_KEYPAD, NTERM);
  wire f_tm = fn_any(sel_flat, term_r, `ITD_FN_SRC_TERM, NTERM);
  wire f_cm = fn_any(sel_flat, term_r, `ITD_FN_SRC_COMM, NTERM);
  wire f_pre = fn_any(sel_flat, term_r, `ITD_FN_PREEXCITE, NTERM);
  wire f_eclr = fn_any(sel_flat, term_r, `ITD_FN_ENERGY_CLR, NTERM);
  wire f_ehold = fn_any(sel_flat, term_r, `ITD_FN_ENERGY_HOLD, NTERM);
  wire f_trq = fn_any(sel_flat, term_r, `ITD_FN_TRQ_KEYPAD, NTERM);
  wire f_pref = fn_any(sel_flat, term_r, `ITD_FN_POS_REF, `ITD_POS_REF_TERMS);
  wire f_orient = fn_any(sel_flat, term_r, `ITD_FN_ORIENT_OFF, NTERM);
  wire f_spos = fn_any(sel_flat, term_r, `ITD_FN_SPINDLE_POS, NTERM);

  // Fixed override priority; with none valid the configured source returns.
  wire itd_src_t src_nxt =
    f_kp ? ITD_SRC_KEYPAD :
    f_tm ? ITD_SRC_TERMINAL :
    f_cm ? ITD_SRC_COMM :
    itd_src_t'(cfg_src_r);

  logic [3:0] edge_prev_r;
  wire [3:0] edge_now = {f_spos, f_eclr, f_dcb, f_cnt_clr};
  wire [3:0] edge_rise = edge_now & ~edge_prev_r;

  // One snapshot of the terminals per cycle, so every decoder in a cycle
  // agrees on which inputs are valid.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      term_r <= '0;
    end else begin
      term_r <= term_in;
    end
  end

  // Pulse requests follow the OR over all terminals that hold a code, so a
  // second terminal joining a function that is already valid fires nothing.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_prev_r <= 4'h0;
    end else begin
      edge_prev_r <= edge_now;
    end
  end

  // Stop drops the hold on the next clock edge, so the core can always ramp down
  // even while a frozen speed is still requested.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ramp_hold <= 1'b0;
    end else begin
      ramp_hold <= f_hold & ~stop_req;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_enable <= 1'b0;
    end else begin
      cnt_enable <= f_cnt_en;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_clear <= 1'b0;
    end else begin
      cnt_clear <= edge_rise[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim_bypass <= 1'b0;
    end else begin
      trim_bypass <= f_trim;
    end
  end

  // Only the rising edge is passed on; how long braking lasts is left to
  // the core.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dc_brake_start <= 1'b0;
    end else begin
      dc_brake_start <= edge_rise[1];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      motor2_sel <= 1'b0;
    end else begin
      motor2_sel <= f_m2;
    end
  end

  // Re-evaluated every cycle, so dropping an override hands control back
  // to the configured source two cycles after the terminal input falls.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_src <= ITD_SRC_KEYPAD;
    end else begin
      run_src <= src_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      preexcite <= 1'b0;
    end else begin
      preexcite <= f_pre;
    end
  end

  // Clear and hold are independent requests and may both stand at once.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      energy_clear <= 1'b0;
    end else begin
      energy_clear <= edge_rise[2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      energy_hold <= 1'b0;
    end else begin
      energy_hold <= f_ehold;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trq_lim_keypad <= 1'b0;
    end else begin
      trq_lim_keypad <= f_trq;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_ref <= 1'b0;
    end else begin
      pos_ref <= f_pref;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      orient_disable <= 1'b0;
    end else begin
      orient_disable <= f_orient;
    end
  end

  // A held positioning input triggers once; it has to be released for at
  // least one sampled cycle before it can trigger again.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spindle_pos_trig <= 1'b0;
    end else begin
      spindle_pos_trig <= edge_rise[3];
    end
  end

  assign status_w = {1'b0, spindle_pos_trig, orient_disable, pos_ref, trq_lim_keypad,
                     energy_hold, energy_clear, preexcite, run_src, motor2_sel,
                     dc_brake_start, trim_bypass, cnt_clear, cnt_enable, ramp_hold};

endmodule

// file: hdl/itd_regs.svh
`ifndef ITD_REGS_SVH
`define ITD_REGS_SVH

// ****************************************
// Function set values
// ****************************************
`define ITD_CODE_W 7
`define ITD_FN_CNT_RESET 7'h1c
`define ITD_FN_RAMP_HOLD 7'h1e
`define ITD_FN_CNT_ENABLE 7'h1f
`define ITD_FN_TRIM_CLEAR 7'h21
`define ITD_FN_DC_BRAKE 7'h22
`define ITD_FN_MOTOR2 7'h23
`define ITD_FN_SRC_KEYPAD 7'h24
`define ITD_FN_SRC_TERM 7'h25
`define ITD_FN_SRC_COMM 7'h26
`define ITD_FN_PREEXCITE 7'h27
`define ITD_FN_ENERGY_CLR 7'h28
`define ITD_FN_ENERGY_HOLD 7'h29
`define ITD_FN_TRQ_KEYPAD 7'h2a
`define ITD_FN_POS_REF 7'h2b
`define ITD_FN_ORIENT_OFF 7'h2c
`define ITD_FN_SPINDLE_POS 7'h2d

// ****************************************
// Register map (byte offsets in the low address byte)
// ****************************************
`define ITD_ADDR_W 8
`define ITD_OFF_SEL_BASE 8'h00
`define ITD_OFF_CFG 8'h40
`define ITD_OFF_STATUS 8'h44
`define ITD_OFF_TERM 8'h48
`define ITD_SEL_MAX_TERMS 16
`define ITD_RST_SEL 7'h00
`define ITD_RST_CFG 2'h0

// ****************************************
// Limits
// ****************************************
`define ITD_POS_REF_TERMS 3
`define ITD_HTRANS_NONSEQ_BIT 1

`endif

// file: hdl/itd_pkg.sv
package itd_pkg;

  typedef enum logic [1:0] {
    ITD_SRC_KEYPAD,
    ITD_SRC_TERMINAL,
    ITD_SRC_COMM
  } itd_src_t;

endpackage

// file: testbench/itd_switch_bank.sv
module itd_switch_bank #(
  parameter int N = 8
) (
  input wire logic hclk, // System clock.
  input wire logic [N-1:0] want, // Switch positions set by the operator.
  output logic [N-1:0] term_in // Levels seen at the terminals.
);
  timeunit 1ns;
  timeprecision 1ns;
  // Contacts settle on the clock, so a level only moves on a sampling edge.
  always_ff @(posedge hclk) term_in <= want;
endmodule

// file: testbench/itd_dispatch_props.sv
module itd_dispatch_chk #(
  parameter int NTERM = 8
) (
  input wire logic hclk, // Clock.
  input wire logic hresetn, // Reset.
  input wire logic [NTERM-1:0] term_in, // Terminals.
  input wire logic stop_req, // Stop.
  input wire logic ramp_hold, // Watched.
  input wire logic cnt_enable, // Watched.
  input wire logic cnt_clear, // Watched.
  input wire logic trim_bypass, // Watched.
  input wire logic dc_brake_start, // Watched.
  input wire logic motor2_sel, // Watched.
  input wire logic preexcite, // Watched.
  input wire logic energy_clear, // Watched.
  input wire logic energy_hold, // Watched.
  input wire logic trq_lim_keypad, // Watched.
  input wire logic pos_ref, // Watched.
  input wire logic orient_disable, // Watched.
  input wire logic spindle_pos_trig // Watched.
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_idle_levels: assert property (
    term_in == '0 |-> ##2 !(cnt_enable | trim_bypass | motor2_sel | preexcite |
      energy_hold | trq_lim_keypad | orient_disable | ramp_hold))
    else $error("level output without a valid terminal");
  a_idle_pulses: assert property (
    term_in == '0 |-> ##2 !(cnt_clear | dc_brake_start | energy_clear | spindle_pos_trig))
    else $error("pulse output without a valid terminal");
  a_stop_wins: assert property (
    stop_req |=> !ramp_hold) else $error("ramp hold kept during stop");
  a_brake_once: assert property (
    $rose(dc_brake_start) |=> !dc_brake_start) else $error("brake pulse too long");
  a_clear_once: assert property (
    cnt_clear |=> !cnt_clear) else $error("counter clear pulse too long");
  a_energy_once: assert property (
    energy_clear |=> !energy_clear) else $error("energy clear pulse too long");
  a_spindle_once: assert property (
    spindle_pos_trig |=> !spindle_pos_trig) else $error("spindle pulse too long");
  a_posref_low: assert property (
    term_in[2:0] == 3'h0 |-> ##2 !pos_ref) else $error("reference point off first three");
endmodule

bind itd_dispatch itd_dispatch_chk #(.NTERM(NTERM)) u_chk (.*);

// file: testbench/test_itd_dispatch.sv
module test_itd_dispatch
  import itd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, stop_req = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] want = 8'h0, term_in;
  wire logic hready;
  logic hreadyout, hresp, ramp_hold, cnt_enable, cnt_clear, trim_bypass, dc_brake_start;
  logic motor2_sel, preexcite, energy_clear, energy_hold, trq_lim_keypad, pos_ref;
  logic orient_disable, spindle_pos_trig;
  itd_src_t run_src;
  int n_mismatch = 0, samples_checked = 0;
  logic [6:0] lc [9] = '{7'h1e, 7'h1f, 7'h21, 7'h23, 7'h27, 7'h29, 7'h2a, 7'h2c, 7'h2b};
  logic [6:0] pc [4] = '{7'h1c, 7'h22, 7'h28, 7'h2d};
  logic [7:0] rv [4] = '{8'h04, 8'h06, 8'h07, 8'h00};
  itd_src_t re [4] = '{ITD_SRC_COMM, ITD_SRC_TERMINAL, ITD_SRC_KEYPAD, ITD_SRC_TERMINAL};
  wire [8:0] lv = {ramp_hold, cnt_enable, trim_bypass, motor2_sel, preexcite, energy_hold,
    trq_lim_keypad, orient_disable, pos_ref};
  wire [3:0] pv = {cnt_clear, dc_brake_start, energy_clear, spindle_pos_trig};
  always #25 hclk = ~hclk;
  assign hready = hreadyout;
  itd_dispatch #(.NTERM(8)) dut (.*);
  itd_switch_bank #(.N(8)) sw (.hclk(hclk), .want(want), .term_in(term_in));
  task end_sim;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdy;
    int i = 0;
    do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 20);
    if (hreadyout !== 1'b1) begin n_mismatch++; end_sim(); end
  endtask
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= wr;
    rdy();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    rdy();
    rd = hrdata;
    check("resp", hresp, 1'b0);
  endtask
  task automatic setsw(input logic [7:0] v);
    want <= v;
    repeat (5) @(posedge hclk);
  endtask
  task automatic pul(input logic [3:0] e);
    logic [15:0] c = 16'h0, b = 16'h0;
    want <= 8'h08;
    repeat (8) begin @(posedge hclk); if (pv === e) c++; else if (pv !== 4'h0) b++; end
    check("pulse", {c, b}, 32'h10000);
    setsw(8'h0);
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 8'h40, 32'h0); check("cfg", rd, 32'h0);
    ahb(1'b0, 8'h4c, 32'h0); check("unmapped", rd, 32'h0);
    for (int k = 0; k < 9; k++) begin
      ahb(1'b1, 8'h04, {25'h0, lc[k]}); ahb(1'b0, 8'h04, 32'h0); check("sel", rd, lc[k]);
      setsw(8'h02); check("level", lv, 9'h100 >> k);
      ahb(1'b0, 8'h48, 32'h0); check("term", rd, 32'h2);
      setsw(8'h00); check("release", lv, 32'h0);
    end
    ahb(1'b1, 8'h00, 32'h1e); setsw(8'h01); stop_req <= 1'b1; setsw(8'h01);
    check("stop", ramp_hold, 1'b0); stop_req <= 1'b0; setsw(8'h00);
    ahb(1'b1, 8'h14, 32'h2b); setsw(8'h20); check("far ref", lv, 32'h0);
    ahb(1'b1, 8'h08, 32'h20); setsw(8'h04); check("undef", {lv, pv}, 32'h0);
    setsw(8'h00);
    for (int k = 0; k < 4; k++) begin ahb(1'b1, 8'h0c, {25'h0, pc[k]}); pul(4'h8 >> k); end
    ahb(1'b1, 8'h40, 32'h1); ahb(1'b1, 8'h40, 32'h3); ahb(1'b0, 8'h40, 32'h0);
    check("cfg", rd, 32'h1);
    ahb(1'b1, 8'h00, 32'h24); ahb(1'b1, 8'h04, 32'h25); ahb(1'b1, 8'h08, 32'h26);
    for (int k = 0; k < 4; k++) begin
      setsw(rv[k]); check("source", run_src, re[k]);
      ahb(1'b0, 8'h44, 32'h0); check("status", rd, {24'h0, re[k], 6'h00});
    end
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge hclk);
    n_mismatch++;
    end_sim();
  end
endmodule
